// ### tb/imi_exec_chk.sv
// Concurrent checks on the ports of the instruction executor.
// Assumes rst is asynchronous and active high, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module imi_exec_chk
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire imi_pkg::imi_op_e instr_op,
    input wire logic ptr_index,
    input wire logic [1:0] index_mode_field,
    input wire logic [5:0] offset,
    input wire logic [7:0] acc,
    input wire logic [15:0] file_select_pointer0,
    input wire logic mem_wr_en,
    input wire logic [15:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic [7:0] option_reg,
    input wire logic reset_instr_flag_n,
    input wire logic device_reset_req,
    input wire logic instr_done,
    input wire logic status_write_block
);
    import imi_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    logic st;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Stores on pointer 0 only, and never while the device reset is pending
    assign st = instr_valid && !device_reset_req && !ptr_index;
    sequence s_reset_out;
        device_reset_req && !reset_instr_flag_n
        ##1 option_reg == IMI_OPTION_RST && file_select_pointer0 == IMI_PTR_RST;
    endsequence
    a_store_data: assert property (st && instr_op == IMI_OP_STORE_MODE |=>
        mem_wr_en && mem_wr_data == $past(acc)) else $error("bad store data");
    a_pre_inc: assert property (st && instr_op == IMI_OP_STORE_MODE && !index_mode_field
        |=> mem_wr_addr == $past(file_select_pointer0) + 16'h0001
        && file_select_pointer0 == mem_wr_addr) else $error("bad pre-increment");
    a_post_inc: assert property (st && instr_op == IMI_OP_STORE_MODE
        && index_mode_field == 2'h2 |=> mem_wr_addr == $past(file_select_pointer0)
        && file_select_pointer0 == mem_wr_addr + 16'h0001) else $error("bad post-increment");
    a_offset_hold: assert property (st && instr_op == IMI_OP_STORE_OFFSET |=>
        mem_wr_addr == $past(file_select_pointer0) + {{10{$past(offset[5])}}, $past(offset)}
        && $stable(file_select_pointer0)) else $error("bad offset store");
    a_option_load: assert property (instr_valid && instr_op == IMI_OP_LOAD_OPTION
        && !device_reset_req |=> option_reg == $past(acc)) else $error("bad option load");
    a_done_pulse: assert property (instr_valid && instr_op != IMI_OP_NONE |=>
        instr_done && status_write_block) else $error("missing done");
    a_nop_quiet: assert property (instr_valid && instr_op == IMI_OP_NOP && !device_reset_req
        |=> !mem_wr_en && $stable(option_reg)) else $error("no-op changed state");
    a_sw_reset: assert property (instr_valid && instr_op == IMI_OP_SW_RESET |=>
        s_reset_out) else $error("bad software reset");
    a_flag_sticky: assert property (!reset_instr_flag_n |=> !reset_instr_flag_n)
        else $error("reset flag set again");
endmodule : imi_exec_chk
bind imi_exec imi_exec_chk u_chk
(
    .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .ptr_index(ptr_index), .index_mode_field(index_mode_field), .offset(offset), .acc(acc),
    .file_select_pointer0(file_select_pointer0), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .option_reg(option_reg),
    .reset_instr_flag_n(reset_instr_flag_n), .device_reset_req(device_reset_req),
    .instr_done(instr_done), .status_write_block(status_write_block)
);
`default_nettype wire

// ### tb/testbench.sv
// Directed bench for imi_exec: stores, offsets, port reads, option, reset.
// Assumes every request is answered at the next clock edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import imi_pkg::*;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    logic clk_sys = 1'h0, rst = 1'h1, instr_valid = 1'h0, ptr_index = 1'h0;
    logic ptr_wr_en = 1'h0, ptr_wr_index = 1'h0, port_rd_req = 1'h0, port_rd_index = 1'h0;
    imi_op_e instr_op = IMI_OP_NONE;
    logic [1:0] index_mode_field = 2'h0;
    logic [5:0] offset = 6'h00;
    logic [7:0] acc = 8'h00, option_reg, mem_wr_data;
    logic [15:0] ptr_wr_data = 16'h0000, file_select_pointer0, file_select_pointer1;
    logic [15:0] mem_wr_addr, indirect_access_port_addr;
    logic mem_wr_en, reset_instr_flag_n, device_reset_req, status_write_block, instr_done;
    int mismatches = 0, comparisons = 0;
    always #5 clk_sys = ~clk_sys;
    imi_exec uut
    (
        .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .ptr_index(ptr_index), .index_mode_field(index_mode_field), .offset(offset),
        .acc(acc), .ptr_wr_en(ptr_wr_en), .ptr_wr_index(ptr_wr_index),
        .ptr_wr_data(ptr_wr_data), .port_rd_req(port_rd_req), .port_rd_index(port_rd_index),
        .file_select_pointer0(file_select_pointer0),
        .file_select_pointer1(file_select_pointer1), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .indirect_access_port_addr(indirect_access_port_addr), .option_reg(option_reg),
        .reset_instr_flag_n(reset_instr_flag_n), .device_reset_req(device_reset_req),
        .status_write_block(status_write_block), .instr_done(instr_done)
    );
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask : step
    // Lowering valid here keeps a held request from issuing twice
    task automatic setp(input logic i, input logic [15:0] v);
        instr_valid = 1'h0;
        ptr_wr_en = 1'h1;
        ptr_wr_index = i;
        ptr_wr_data = v;
        step;
    endtask : setp
    task automatic issue(input imi_op_e op, input logic [1:0] m, input logic [5:0] k);
        ptr_wr_en = 1'h0;
        instr_valid = 1'h1;
        instr_op = op;
        index_mode_field = m;
        offset = k;
        acc = acc + 8'h3B;
        step;
    endtask : issue
    task automatic t_store;
        logic [15:0] b, n;
        for (int m = 0; m < 4; m++)
        begin
            b = m[0] ? 16'h0000 : 16'hFFFF;
            n = m[0] ? b - 16'h0001 : b + 16'h0001;
            ptr_index = m[0];
            setp(m[0], b);
            issue(IMI_OP_STORE_MODE, m[1:0], 6'h00);
            check(mem_wr_data, acc);
            check(mem_wr_addr, m[1] ? b : n);
            check(m[0] ? file_select_pointer1 : file_select_pointer0, n);
            check(status_write_block, 1'h1);
        end
        ptr_index = 1'h0;
        $display("t_store done");
    endtask : t_store
    task automatic t_offset;
        setp(1'h1, 16'h1234);
        setp(1'h0, 16'h0010);
        issue(IMI_OP_STORE_OFFSET, 2'h0, 6'h20);
        check(mem_wr_addr, 16'hFFF0);
        issue(IMI_OP_STORE_OFFSET, 2'h0, 6'h1F);
        check(mem_wr_addr, 16'h002F);
        check(file_select_pointer0, 16'h0010);
        instr_valid = 1'h0;
        port_rd_req = 1'h1;
        port_rd_index = 1'h1;
        step;
        port_rd_req = 1'h0;
        check(indirect_access_port_addr, 16'h1234);
        $display("t_offset done");
    endtask : t_offset
    task automatic t_option;
        check(option_reg, 8'hFF);
        issue(IMI_OP_LOAD_OPTION, 2'h0, 6'h00);
        check(option_reg, acc);
        issue(IMI_OP_NOP, 2'h0, 6'h00);
        check(instr_done, 1'h1);
        check(mem_wr_en, 1'h0);
        check(option_reg, 8'(acc - 8'h3B));
        $display("t_option done");
    endtask : t_option
    task automatic t_reset;
        check(reset_instr_flag_n, 1'h1);
        issue(IMI_OP_SW_RESET, 2'h0, 6'h00);
        check(device_reset_req, 1'h1);
        check(reset_instr_flag_n, 1'h0);
        instr_valid = 1'h0;
        step;
        check(option_reg, 8'hFF);
        check(file_select_pointer0, 16'h0000);
        step;
        check(reset_instr_flag_n, 1'h0);
        rst = 1'h1;
        step;
        rst = 1'h0;
        step;
        check(reset_instr_flag_n, 1'h1);
        $display("t_reset done");
    endtask : t_reset
    initial
    begin
        #100000;
        mismatches++;
        finish_test;
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        t_store;
        t_offset;
        t_option;
        t_reset;
        finish_test;
    end
endmodule : testbench
`default_nettype wire

// ### verilog/imi_addr_calc.sv
// Effective-address and pointer-update arithmetic for the indirect store.
// Assumes pure combinational use by the executor; no state held here.
`timescale 1ns/10ps
`default_nettype none
module imi_addr_calc
(
    input wire logic [15:0] ptr,
    input wire logic [1:0] index_mode_field,
    input wire logic use_offset,
    input wire logic [5:0] offset,
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_nxt
);
    import imi_pkg::*;

    logic [15:0] stepped;
    logic [15:0] off_ext;

    // Modulo 2^16 add drops the carry, giving wrap both ways
    always_comb
    begin
        stepped = index_mode_field[IMI_MODE_DEC_BIT] ? ptr - 16'h0001 : ptr + 16'h0001;
        off_ext = {{10{offset[5]}}, offset};
        if (use_offset)
        begin
            eff_addr = ptr + off_ext;
            ptr_nxt = ptr;
        end
        else
        begin
            eff_addr = index_mode_field[IMI_MODE_POST_BIT] ? ptr : stepped;
            ptr_nxt = stepped;
        end
    end
endmodule : imi_addr_calc
`default_nettype wire

// ### verilog/imi_exec.sv
// Executor for indirect store, no-operation, load-option and software reset.
// Assumes the fetch stage presents one decoded instruction per valid strobe
// and that data memory accepts one write per cycle.
`timescale 1ns/10ps
`default_nettype none
module imi_exec
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire imi_pkg::imi_op_e instr_op,
    input wire logic ptr_index,
    input wire logic [1:0] index_mode_field,
    input wire logic [5:0] offset,
    input wire logic [7:0] acc,
    input wire logic ptr_wr_en,
    input wire logic ptr_wr_index,
    input wire logic [15:0] ptr_wr_data,
    input wire logic port_rd_req,
    input wire logic port_rd_index,
    output logic [15:0] file_select_pointer0,
    output logic [15:0] file_select_pointer1,
    output logic mem_wr_en,
    output logic [15:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic [15:0] indirect_access_port_addr,
    output logic [7:0] option_reg,
    output logic reset_instr_flag_n,
    output logic device_reset_req,
    output logic status_write_block,
    output logic instr_done
);
    import imi_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The reset request is a single registered pulse; a longer one would need a counter
    if (IMI_RESET_PULSE_CYCLES != 1)
    begin : g_bad_pulse
        $error("imi_exec: software reset pulse must last one cycle");
    end
    if ($bits(IMI_PTR_RST) != 16)
    begin : g_bad_ptr_rst
        $error("imi_exec: pointer reset value must be 16 bits wide");
    end
    if ($bits(IMI_OPTION_RST) != 8)
    begin : g_bad_opt_rst
        $error("imi_exec: option reset value must be 8 bits wide");
    end

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Valid strobe qualified by one decoded opcode
    function automatic logic op_hit(input logic valid, input imi_op_e op, input imi_op_e want);
        return valid && (op == want);
    endfunction : op_hit

    // Pointer chosen by a one-bit index, shared by stores and port reads
    function automatic logic [15:0] ptr_pick(input logic idx, input logic [15:0] p0,
                                             input logic [15:0] p1);
        return idx ? p1 : p0;
    endfunction : ptr_pick

    // ************************************************************
    // Address arithmetic
    // ************************************************************
    logic [15:0] ptr_sel;
    logic [15:0] eff_addr;
    logic [15:0] ptr_upd;
    logic is_store;
    logic is_offset;
    logic is_sw_reset;
    logic is_load_option;

    assign ptr_sel = ptr_pick(ptr_index, file_select_pointer0, file_select_pointer1);
    assign is_offset = instr_op == IMI_OP_STORE_OFFSET;
    assign is_store = op_hit(instr_valid, instr_op, IMI_OP_STORE_MODE)
                      || op_hit(instr_valid, instr_op, IMI_OP_STORE_OFFSET);
    assign is_sw_reset = op_hit(instr_valid, instr_op, IMI_OP_SW_RESET);
    assign is_load_option = op_hit(instr_valid, instr_op, IMI_OP_LOAD_OPTION);

    imi_addr_calc u_addr_calc
    (
        .ptr(ptr_sel),
        .index_mode_field(index_mode_field),
        .use_offset(is_offset),
        .offset(offset),
        .eff_addr(eff_addr),
        .ptr_nxt(ptr_upd)
    );

    // ************************************************************
    // Pointer registers
    // ************************************************************
    // Instruction update wins over a direct write to the same pointer in one cycle;
    // a pending software reset beats both, so a store issued with it is dropped
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            file_select_pointer0 <= IMI_PTR_RST;
        else if (device_reset_req)
            file_select_pointer0 <= IMI_PTR_RST;
        else if (is_store && !ptr_index)
            file_select_pointer0 <= ptr_upd;
        else if (ptr_wr_en && !ptr_wr_index)
            file_select_pointer0 <= ptr_wr_data;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            file_select_pointer1 <= IMI_PTR_RST;
        else if (device_reset_req)
            file_select_pointer1 <= IMI_PTR_RST;
        else if (is_store && ptr_index)
            file_select_pointer1 <= ptr_upd;
        else if (ptr_wr_en && ptr_wr_index)
            file_select_pointer1 <= ptr_wr_data;
    end

    // ************************************************************
    // Data memory write
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mem_wr_en <= 1'b0;
            mem_wr_addr <= IMI_PTR_RST;
            mem_wr_data <= 8'h00;
        end
        else
        begin
            mem_wr_en <= is_store && !device_reset_req;
            if (is_store)
            begin
                mem_wr_addr <= eff_addr;
                mem_wr_data <= acc;
            end
        end
    end

    // ************************************************************
    // Indirect port redirection
    // ************************************************************
    // No storage behind the port: reads resolve to the pointer's target
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            indirect_access_port_addr <= IMI_PTR_RST;
        else if (port_rd_req)
            indirect_access_port_addr <= ptr_pick(port_rd_index, file_select_pointer0,
                                                  file_select_pointer1);
    end

    // ************************************************************
    // Option register and status protection
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            option_reg <= IMI_OPTION_RST;
        else if (device_reset_req)
            option_reg <= IMI_OPTION_RST;
        else if (is_load_option)
            option_reg <= acc;
    end

    // Tells the flag logic elsewhere that this cycle's instruction leaves flags alone
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            status_write_block <= 1'b0;
        else
            status_write_block <= instr_valid && instr_op != IMI_OP_NONE;
    end

    // ************************************************************
    // Software reset and completion
    // ************************************************************
    // The flag survives the reset it causes; only a hardware reset sets it again
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reset_instr_flag_n <= IMI_RI_FLAG_RST;
        else if (is_sw_reset)
            reset_instr_flag_n <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            device_reset_req <= 1'b0;
        else
            device_reset_req <= is_sw_reset;
    end

    // Every instruction here completes in a single cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            instr_done <= 1'b0;
        else
        begin
            case (instr_op)
                IMI_OP_NOP,
                IMI_OP_STORE_MODE,
                IMI_OP_STORE_OFFSET,
                IMI_OP_LOAD_OPTION,
                IMI_OP_SW_RESET: instr_done <= instr_valid;
                default: instr_done <= 1'b0;
            endcase
        end
    end
endmodule : imi_exec
`default_nettype wire

// ### verilog/imi_pkg.sv
// Package for the indirect store and miscellaneous instruction executor.
// Assumes a single 100 MHz clock and one instruction issued per strobe.
package imi_pkg;
    // ************************************************************
    // Opcodes presented on the decoded instruction port
    // ************************************************************
    typedef enum logic [2:0]
    {
        IMI_OP_NONE,
        IMI_OP_NOP,
        IMI_OP_STORE_MODE,
        IMI_OP_STORE_OFFSET,
        IMI_OP_LOAD_OPTION,
        IMI_OP_SW_RESET
    } imi_op_e;

    // ************************************************************
    // Field encodings and reset values
    // ************************************************************
    localparam logic [1:0] IMI_MODE_PRE_INC = 2'h0;
    localparam logic [1:0] IMI_MODE_PRE_DEC = 2'h1;
    localparam logic [1:0] IMI_MODE_POST_INC = 2'h2;
    localparam logic [1:0] IMI_MODE_POST_DEC = 2'h3;
    localparam int IMI_MODE_POST_BIT = 1;
    localparam int IMI_MODE_DEC_BIT = 0;
    localparam logic [7:0] IMI_OPTION_RST = 8'hFF;
    localparam logic [15:0] IMI_PTR_RST = 16'h0000;
    localparam logic IMI_RI_FLAG_RST = 1'b1;
    localparam int IMI_RESET_PULSE_CYCLES = 1;
endpackage : imi_pkg
